// ### design/ssd_dir_mem.v
`timescale 1ns/1ns
`include "ssd_map.vh"

module ssd_dir_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 3,
  parameter AW    = 2
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer         i;

  // Port pins come out of reset as inputs, so every word resets to all ones.
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= `SSD_DIR_RST;
      end
      rdata <= `SSD_DIR_RST;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= (raddr < DEPTH) ? mem[raddr] : {WIDTH{1'b0}};
    end
  end

endmodule // ssd_dir_mem

// ### design/ssd_exec.v
// Notes on behaviour
// - Subtract: file minus accumulator, update C, half-nibble, Z.
// - Subtract result to accumulator or file by dest.
// - Exchange nibbles of file register; flags untouched.
// - Exchange result to accumulator or file by dest.
// - Direction load copies accumulator to selected direction register.
`timescale 1ns/1ns
`include "ssd_map.vh"

module ssd_exec #(
  parameter DW = 8,
  parameter FW = 5
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          exec_valid,
  input  wire [11:0]   exec_opcode,
  input  wire [DW-1:0] file_rdata,
  output reg           file_we,
  output reg  [FW-1:0] file_addr,
  output reg  [DW-1:0] file_wdata,
  output reg  [DW-1:0] accum,
  output reg           flag_we,
  output reg           flag_carry,
  output reg           flag_half_nibble_bit,
  output reg           flag_zero,
  output reg           dir_we,
  output reg  [2:0]    dir_sel,
  output reg  [DW-1:0] dir_data,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready
);

  // Register selector codes: 0 accum, 1 flags, 2..4 direction words, 7 unmapped.
  function [2:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `SSD_ACCUM_OFS: reg_sel = 3'h0;
        `SSD_FLAGS_OFS: reg_sel = 3'h1;
        `SSD_DIR0_OFS:  reg_sel = 3'h2;
        `SSD_DIR1_OFS:  reg_sel = 3'h3;
        `SSD_DIR2_OFS:  reg_sel = 3'h4;
        default:        reg_sel = 3'h7;
      endcase
    end
  endfunction

  wire [FW-1:0] fsel    = exec_opcode[`SSD_FILE_HI:`SSD_FILE_LO];
  wire          dest    = exec_opcode[`SSD_DEST_BIT];
  wire          is_sub  = exec_valid &&
                          ((exec_opcode & `SSD_SUB_MASK) == `SSD_SUB_PAT);
  wire          is_swap = exec_valid &&
                          ((exec_opcode & `SSD_SWAP_MASK) == `SSD_SWAP_PAT);
  wire          is_dir  = exec_valid &&
                          ((exec_opcode & `SSD_DIR_MASK) == `SSD_DIR_PAT) &&
                          (exec_opcode[2:0] >= `SSD_DIR_FIRST) &&
                          (exec_opcode[2:0] <= `SSD_DIR_LAST);

  // The extra top bit is the borrow, so carry is its inverse; two's complement wraps the low byte.
  wire [DW:0]   diff     = {1'b0, file_rdata} - {1'b0, accum};
  wire [4:0]    low_diff = {1'b0, file_rdata[3:0]} - {1'b0, accum[3:0]};
  wire [DW-1:0] swapped  = {file_rdata[3:0], file_rdata[7:4]};
  wire [DW-1:0] result   = is_sub ? diff[DW-1:0] : swapped;

  wire          aw_hs = s_axi_awvalid && s_axi_awready;
  wire          w_hs  = s_axi_wvalid && s_axi_wready;
  wire          ar_hs = s_axi_arvalid && s_axi_arready;

  reg           aw_got;
  reg           w_got;
  reg  [7:0]    aw_addr;
  reg  [31:0]   w_data;
  reg           w_strb0;
  reg  [7:0]    ar_addr;
  reg           rd_stage;
  reg           rd_busy;
  reg           next_aw_got;
  reg           next_w_got;
  reg           next_rd_busy;
  // A write that has both halves waits while its response is still unclaimed.
  // This keeps bresp from being overwritten before the master has taken it.
  wire          do_write = aw_got && w_got && !s_axi_bvalid;
  wire [2:0]    wsel     = reg_sel(aw_addr);
  wire [2:0]    rsel     = reg_sel(ar_addr);
  wire [2:0]    mem_rsel = reg_sel(s_axi_araddr);
  wire [DW-1:0] mem_q;

  always @* begin
    next_aw_got  = (aw_got | aw_hs) & ~do_write;
    next_w_got   = (w_got | w_hs) & ~do_write;
    next_rd_busy = (rd_busy | ar_hs) & ~(s_axi_rvalid & s_axi_rready);
  end

  // Direction fields 5 to 7 fold onto words 0 to 2; bus offsets fold the same way.
  // A load in the same cycle as a read handshake is not seen by that read.
  ssd_dir_mem #(
    .WIDTH (DW),
    .DEPTH (3),
    .AW    (2)
  ) ssd_dir_mem_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (is_dir),
    .waddr   (exec_opcode[1:0] - 2'h1),
    .wdata   (accum),
    .raddr   (mem_rsel[1:0] - 2'h2),
    .rdata   (mem_q)
  );

  // Execution path.
  always @(posedge aclk) begin
    if (!aresetn) begin
      file_we              <= 1'b0;
      file_addr            <= {FW{1'b0}};
      file_wdata           <= {DW{1'b0}};
      accum                <= `SSD_ACCUM_RST;
      flag_we              <= 1'b0;
      flag_carry           <= 1'b0;
      flag_half_nibble_bit <= 1'b0;
      flag_zero            <= 1'b0;
      dir_we               <= 1'b0;
      dir_sel              <= 3'h0;
      dir_data             <= {DW{1'b0}};
    end else begin
      file_we    <= (is_sub || is_swap) && dest;
      file_addr  <= fsel;
      file_wdata <= result;
      flag_we    <= is_sub;
      if (is_sub) begin
        flag_carry           <= ~diff[DW];
        flag_half_nibble_bit <= ~low_diff[4];
        flag_zero            <= (diff[DW-1:0] == {DW{1'b0}});
      end
      // An instruction that targets the accumulator wins over a bus write.
      if ((is_sub || is_swap) && !dest) begin
        accum <= result;
      end else if (do_write && wsel == 3'h0 && w_strb0) begin
        accum <= w_data[DW-1:0];
      end
      dir_we   <= is_dir;
      dir_sel  <= exec_opcode[2:0];
      dir_data <= accum;
    end
  end

  // Bus slave. Address and data may arrive in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSD_RESP_OKAY;
      ar_addr       <= 8'h00;
      rd_stage      <= 1'b0;
      rd_busy       <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SSD_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      s_axi_awready <= ~next_aw_got;
      s_axi_wready  <= ~next_w_got;
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data  <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == 3'h0) ? `SSD_RESP_OKAY : `SSD_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // The direction memory answers one cycle late, hence the extra stage.
      rd_busy       <= next_rd_busy;
      s_axi_arready <= ~next_rd_busy;
      rd_stage      <= ar_hs;
      if (ar_hs) begin
        ar_addr <= s_axi_araddr;
      end
      if (rd_stage) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (rsel == 3'h7) ? `SSD_RESP_SLVERR : `SSD_RESP_OKAY;
        case (rsel)
          3'h0:    s_axi_rdata <= {24'h00_0000, accum};
          3'h1:    s_axi_rdata <= {29'h0000_0000, flag_carry,
                                   flag_half_nibble_bit, flag_zero};
          3'h2,
          3'h3,
          3'h4:    s_axi_rdata <= {24'h00_0000, mem_q};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ssd_exec

// ### design/ssd_map.vh
`ifndef SSD_MAP_VH
`define SSD_MAP_VH

// Opcode decode: mask and pattern pairs, plus the direction field range.
`define SSD_SUB_MASK   12'h0FC0
`define SSD_SUB_PAT    12'h0080
`define SSD_SWAP_MASK  12'h0FC0
`define SSD_SWAP_PAT   12'h0380
`define SSD_DIR_MASK   12'h0FF8
`define SSD_DIR_PAT    12'h0000
`define SSD_DIR_FIRST  3'h5
`define SSD_DIR_LAST   3'h7

// Opcode field positions.
`define SSD_DEST_BIT   5
`define SSD_FILE_HI    4
`define SSD_FILE_LO    0

// Register byte offsets.
`define SSD_ACCUM_OFS  8'h00
`define SSD_FLAGS_OFS  8'h04
`define SSD_DIR0_OFS   8'h08
`define SSD_DIR1_OFS   8'h0C
`define SSD_DIR2_OFS   8'h10

// Flag register bit positions.
`define SSD_FLAG_Z     0
`define SSD_FLAG_HNB   1
`define SSD_FLAG_C     2

// Reset values.
`define SSD_ACCUM_RST  8'h00
`define SSD_DIR_RST    8'hFF

// Bus response codes.
`define SSD_RESP_OKAY  2'h0
`define SSD_RESP_SLVERR 2'h2

`endif

// ### sim/ssd_exec_asserts.sv
`timescale 1ns/1ns
module ssd_exec_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        exec_valid,
  input wire [11:0] exec_opcode,
  input wire [7:0]  file_rdata,
  input wire        file_we,
  input wire [4:0]  file_addr,
  input wire [7:0]  file_wdata,
  input wire [7:0]  accum,
  input wire        flag_we,
  input wire        flag_carry,
  input wire        flag_half_nibble_bit,
  input wire        flag_zero,
  input wire        dir_we,
  input wire [2:0]  dir_sel,
  input wire [7:0]  dir_data
);
  wire       sub = exec_valid && exec_opcode[11:6] == 6'h02;
  wire       swp = exec_valid && exec_opcode[11:6] == 6'h0e;
  wire       dl  = exec_valid && exec_opcode[11:3] == 9'h000 && exec_opcode[2:0] >= 3'h5;
  wire       d   = exec_opcode[5];
  wire [2:0] fl  = {flag_carry, flag_half_nibble_bit, flag_zero};
  wire [7:0] sw  = {file_rdata[3:0], file_rdata[7:4]};
  // Results land one edge after the instruction, so each check looks one cycle back.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SUB: assert property (sub |=> file_we == $past(d)
    && ($past(d) ? file_wdata : accum) == $past(file_rdata) - $past(accum))
    else $error("bad difference");
  AST_FLAG: assert property (sub |=> flag_carry == ($past(file_rdata) >= $past(accum))
    && flag_zero == ($past(file_rdata) == $past(accum))
    && flag_half_nibble_bit == ($past(file_rdata[3:0]) >= $past(accum[3:0])))
    else $error("bad flags");
  AST_SWAP: assert property (swp |=> file_we == $past(d)
    && ($past(d) ? file_wdata : accum) == $past(sw)) else $error("bad exchange");
  AST_DIR: assert property (dl |=> dir_we && dir_sel == $past(exec_opcode[2:0])
    && dir_data == $past(accum)) else $error("bad direction load");
  AST_DIR_OFF: assert property (!dl |=> !dir_we) else $error("stray direction load");
  AST_HOLD: assert property (!sub |=> $stable(fl)) else $error("flags moved");
  AST_FLAG_WE: assert property (1'b1 |=> flag_we == $past(sub))
    else $error("bad flag strobe");
  AST_ADDR: assert property ((sub || swp) |=> file_addr == $past(exec_opcode[4:0]))
    else $error("bad file address");
  AST_FILE_OFF: assert property (!(sub || swp) |=> !file_we)
    else $error("stray file write");
endmodule // ssd_exec_asserts

bind ssd_exec ssd_exec_asserts ssd_exec_asserts_inst (.aclk, .aresetn, .exec_valid,
  .exec_opcode, .file_rdata, .file_we, .file_addr, .file_wdata, .accum, .flag_we, .flag_carry,
  .flag_half_nibble_bit, .flag_zero, .dir_we, .dir_sel, .dir_data);

// ### sim/ssd_exec_tb.sv
`timescale 1ns/1ns
`define CK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module ssd_exec_tb;
  logic        aclk, aresetn, ev, fwe, fc, fh, fz, dwe, awv, awr, wv, wr_, bv, brd, arv, arr;
  logic        rv, rrd;
  logic [11:0] op;
  logic [7:0]  frd, fwd, acc, dd, awa, ara;
  logic [4:0]  fa;
  logic [2:0]  dsel;
  logic [31:0] wd, rd_;
  logic [1:0]  br, rr;
  logic [3:0]  ws;
  logic [7:0]  tv [4] = '{8'h03, 8'h02, 8'h01, 8'h10};
  int          mismatches, n_compared, i;
  ssd_exec ssd_exec_inst (.aclk, .aresetn, .exec_valid(ev), .exec_opcode(op), .file_rdata(frd),
    .file_we(fwe), .file_addr(fa), .file_wdata(fwd), .accum(acc), .flag_we(), .flag_carry(fc),
    .flag_half_nibble_bit(fh), .flag_zero(fz), .dir_we(dwe), .dir_sel(dsel), .dir_data(dd),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrd));
  ssd_file_model fm (.aclk, .raddr(op[4:0]), .rdata(frd), .we(fwe), .waddr(fa), .wdata(fwd));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic go(input logic [11:0] o);
    @(posedge aclk);
    ev <= 1'b1;
    op <= o;
  endtask
  task automatic halt;
    @(posedge aclk);
    ev <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
    end while (!bv);
    brd <= 1'b0;
    `CK("bresp", r, br)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rrd <= 1'b0;
    `CK("rdata", e, rd_)
    `CK("rresp", r, rr)
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    stop_test;
  end
  initial begin
    {aresetn, ev, op, awv, wv, brd, arv, rrd, awa, ara, wd} = '0;
    ws = 4'h1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0000_0000, 2'h0);
    rd(8'h08, 32'h0000_00ff, 2'h0);
    wr(8'h00, 32'h0000_0002, 2'h0);
    for (i = 0; i < 4; i++) begin
      fm.mem[1] = tv[i];
      go(12'h0a1);
      halt;
      `CK("diff", tv[i] - 8'h02, fwd)
      rd(8'h04, {tv[i] >= 8'h02, tv[i][3:0] >= 4'h2, tv[i] == 8'h02}, 2'h0);
    end
    fm.mem[2] = 8'h10;
    go(12'h082);
    go(12'h082);
    halt;
    rd(8'h00, 32'h0000_0002, 2'h0);
    fm.mem[3] = 8'ha5;
    go(12'h383);
    go(12'h3a3);
    halt;
    `CK("swap", 8'h5a, fwd)
    rd(8'h00, 32'h0000_005a, 2'h0);
    rd(8'h04, 32'h0000_0004, 2'h0);
    for (i = 4; i < 8; i++) begin
      wr(8'h00, 32'h0000_0030 + i, 2'h0);
      go(i[11:0]);
      halt;
      `CK("dir_we", i > 4, dwe)
      if (i > 4) rd(8'h08 + 8'(4 * (i - 5)), 32'h0000_0030 + i, 2'h0);
    end
    wr(8'h04, 32'h0000_0001, 2'h2);
    rd(8'h20, 32'h0000_0000, 2'h2);
    stop_test;
  end
endmodule // ssd_exec_tb

// ### sim/ssd_file_model.sv
`timescale 1ns/1ns
module ssd_file_model (
  input  wire       aclk,
  input  wire [4:0] raddr,
  output wire [7:0] rdata,
  input  wire       we,
  input  wire [4:0] waddr,
  input  wire [7:0] wdata
);
  logic [7:0] mem [0:31];
  // Reads are combinational because the core reads and executes in one cycle.
  assign rdata = mem[raddr];
  always @(posedge aclk) if (we) mem[waddr] <= wdata;
endmodule // ssd_file_model
